// File: mpsp_defines.svh
`ifndef MPSP_DEFINES_SVH
`define MPSP_DEFINES_SVH

// Width of the byte address on the register port.
`define MPSP_ADDR_W        12
// Width of the register data path.
`define MPSP_DATA_W        32

// Byte offsets of the three policy registers.
`define MPSP_OFF_PRIV_LO   12'h200
`define MPSP_OFF_PRIV_HI   12'h204
`define MPSP_OFF_SEC       12'h218

// Reset value shared by every policy register.
`define MPSP_RST_VAL       32'h0000_0000

// Implemented bit masks; all other bits are reserved.
`define MPSP_MASK_SEC      32'hffff_fffc
`define MPSP_MASK_PRIV_LO  32'hffff_fffc
`define MPSP_MASK_PRIV_HI  32'h0000_0003

// Odd positions are lock bits, even positions are indicators.
`define MPSP_LOCK_POS      32'haaaa_aaaa
`define MPSP_IND_POS       32'h5555_5555

// Number of bit pairs in one register.
`define MPSP_PAIRS         16
// Master groups with a security indicator.
`define MPSP_SEC_GROUPS    15
// Master groups with a privilege indicator.
`define MPSP_PRIV_GROUPS   16

// Read value for reserved bits and unmapped addresses.
`define MPSP_RD_ZERO       32'h0000_0000

// Pair index of each master group. One index serves both the security
// register and the first privilege register, whose layouts agree.
`define MPSP_PAIR_DMA_B        15
`define MPSP_PAIR_DEBUG_PORT   14
`define MPSP_PAIR_AUX_MASTER   13
`define MPSP_PAIR_SDHOST_C     12
`define MPSP_PAIR_SDHOST_B     11
`define MPSP_PAIR_SDHOST_A     10
`define MPSP_PAIR_ETHERNET     9
`define MPSP_PAIR_NAND_DMA     8
`define MPSP_PAIR_GRAPHICS     7
`define MPSP_PAIR_VIDEO_DEC    6
`define MPSP_PAIR_PCIE         5
`define MPSP_PAIR_USB          4
`define MPSP_PAIR_DISPLAY      3
`define MPSP_PAIR_DMA_A        2
`define MPSP_PAIR_AUX_CORE     1
// The crypto accelerator owns the only pair of the second privilege register.
`define MPSP_PAIR_CRYPTO       0

`endif

// File: mpsp_pkg.sv
package mpsp_pkg;

   // One register port request, sampled on the rising clock edge.
   typedef struct packed
   {
      logic [11:0] addr;   // Byte address.
      logic [31:0] wdata;  // Write data.
      logic        wr;     // Write strobe, one cycle.
      logic        rd;     // Read strobe, one cycle.
   } mpsp_bus_req_t;

   // Attributes driven toward the master groups.
   typedef struct packed
   {
      logic [14:0] nonsecure;  // One per security group, 1 = non-secure.
      logic [15:0] privilege;  // One per privilege group, 1 = supervisor.
   } mpsp_attr_t;

endpackage : mpsp_pkg

// File: mpsp_policy.sv
// Decided for this implementation: the plain strobed port.
`timescale 1ns/10ps
`include "mpsp_defines.svh"

module mpsp_policy
(
   input  wire logic                        i_clk,
   input  wire logic                        i_arst_n,
   input  wire mpsp_pkg::mpsp_bus_req_t     i_bus,
   output logic [`MPSP_DATA_W-1:0]          o_rdata,
   input  wire logic [`MPSP_PRIV_GROUPS-1:0] i_priv_override_sel,
   input  wire logic [`MPSP_PRIV_GROUPS-1:0] i_priv_in,
   output mpsp_pkg::mpsp_attr_t             o_attr
);

   // Merges a write into a register of lock/indicator pairs.
   // Locks only ever gain ones, so software can never unlock a pair.
   // An indicator follows the write only while its own lock was clear
   // before the write; a write that sets lock and indicator together
   // therefore still lands the indicator, then freezes it.
   function automatic logic [31:0] pair_write
   (
      input logic [31:0] old_val,
      input logic [31:0] wdata,
      input logic [31:0] impl_mask
   );
      logic [31:0] lock_mask;
      logic [31:0] ind_mask;
      logic [31:0] frozen;
      logic [31:0] new_lock;
      logic [31:0] new_ind;
      lock_mask = impl_mask & `MPSP_LOCK_POS;
      ind_mask  = impl_mask & `MPSP_IND_POS;
      // Writing zero to a set lock is ignored rather than refused.
      // locks are sticky
      new_lock  = (old_val | wdata) & lock_mask;
      // Shifting right by one lines each lock up with its own indicator;
      // a pair locked before this write keeps its old indicator.
      // lock freezes indicator
      frozen    = {1'b0, old_val[31:1]} & ind_mask;
      new_ind   = ((frozen & old_val) | (~frozen & wdata)) & ind_mask;
      // Masking with the implemented bits drops reserved positions.
      // reserved bits stay zero
      pair_write = new_lock | new_ind;
   endfunction : pair_write

   // Gathers the indicator (even) bit of every pair into one vector.
   function automatic logic [`MPSP_PAIRS-1:0] indicators
   (
      input logic [31:0] val
   );
      logic [`MPSP_PAIRS-1:0] res;
      res = '0;
      for (int k = 0; k < `MPSP_PAIRS; k++)
      begin
         res[k] = val[2*k];
      end
      indicators = res;
   endfunction : indicators

   // Stored register contents.
   // Only implemented bits can ever become one.
   logic [31:0] master_security_policy;   // Security pairs.
   logic [31:0] master_privilege_low;     // First privilege pairs.
   logic [31:0] master_privilege_high;    // Second privilege pair.

   // Next values of the stored registers.
   // Each holds its old value unless its own register is written.
   logic [31:0] next_master_security_policy;
   logic [31:0] next_master_privilege_low;
   logic [31:0] next_master_privilege_high;

   // Address decode results.
   logic        hit_sec;       // Address names the security register.
   logic        hit_priv_lo;   // Address names the first privilege register.
   logic        hit_priv_hi;   // Address names the second privilege register.

   // Write enables per register.
   logic        wr_sec;
   logic        wr_priv_lo;
   logic        wr_priv_hi;

   // Read data selected in the strobe cycle.
   logic [31:0] rd_sel;
   // Next value of the registered read data.
   logic [31:0] next_rdata;

   // Indicator vectors taken from the stored registers.
   logic [`MPSP_PAIRS-1:0] sec_ind;
   logic [`MPSP_PAIRS-1:0] priv_lo_ind;
   logic [`MPSP_PAIRS-1:0] priv_hi_ind;

   // Stored privilege per group, group 0 being the crypto accelerator.
   logic [`MPSP_PRIV_GROUPS-1:0] privilege_stored;

   // Security indicator per master group, 1 meaning non-secure.
   logic        nonsecure_sel_dma_b;        // Second system DMA.
   logic        nonsecure_sel_debug_port;   // Debug access port.
   logic        nonsecure_sel_aux_master;   // Auxiliary master.
   logic        nonsecure_sel_sdhost_c;     // Third SD host controller.
   logic        nonsecure_sel_sdhost_b;     // Second SD host controller.
   logic        nonsecure_sel_sdhost_a;     // First SD host controller.
   logic        nonsecure_sel_ethernet;     // Ethernet controller.
   logic        nonsecure_sel_nand_dma;     // Raw NAND DMA.
   logic        nonsecure_sel_graphics;     // Graphics processor.
   logic        nonsecure_sel_video_dec;    // Video decoder.
   logic        nonsecure_sel_pcie;         // PCIe controllers.
   logic        nonsecure_sel_usb;          // USB controllers.
   logic        nonsecure_sel_display;      // Display controller.
   logic        nonsecure_sel_dma_a;        // First system DMA.
   logic        nonsecure_sel_aux_core;     // Auxiliary core.

   // Stored privilege indicator per master group, 1 meaning supervisor.
   // These only reach a master while its override select is set.
   logic        privilege_dma_b;            // Second system DMA.
   logic        privilege_debug_port;       // Debug access port.
   logic        privilege_aux_master;       // Auxiliary master.
   logic        privilege_sdhost_c;         // Third SD host controller.
   logic        privilege_sdhost_b;         // Second SD host controller.
   logic        privilege_sdhost_a;         // First SD host controller.
   logic        privilege_ethernet;         // Ethernet controller.
   logic        privilege_nand_dma;         // Raw NAND DMA.
   logic        privilege_graphics;         // Graphics processor.
   logic        privilege_video_dec;        // Video decoder.
   logic        privilege_pcie;             // PCIe controllers.
   logic        privilege_usb;              // USB controllers.
   logic        privilege_display;          // Display controller.
   logic        privilege_dma_a;            // First system DMA.
   logic        privilege_aux_core;         // Auxiliary core.
   logic        privilege_crypto_master;    // Crypto accelerator.

   // Next values of the attribute outputs.
   mpsp_pkg::mpsp_attr_t next_attr;

   // Comparing all twelve bits costs a little logic but keeps aliases
   // of the registers out of the map, so a stray write cannot land.
   // Full byte address compare: misaligned addresses are unmapped.
   // security register offset
   assign hit_sec     = (i_bus.addr == `MPSP_OFF_SEC);
   assign hit_priv_lo = (i_bus.addr == `MPSP_OFF_PRIV_LO);
   // The second privilege register sits in the next word.
   assign hit_priv_hi = (i_bus.addr == `MPSP_OFF_PRIV_HI);

   // A write only affects the register that it addresses.
   // Reads have no side effect, so only writes are qualified here.
   assign wr_sec     = i_bus.wr & hit_sec;
   assign wr_priv_lo = i_bus.wr & hit_priv_lo;
   assign wr_priv_hi = i_bus.wr & hit_priv_hi;

   assign next_master_security_policy = wr_sec ?
      pair_write(master_security_policy, i_bus.wdata, `MPSP_MASK_SEC) :
      master_security_policy;

   assign next_master_privilege_low = wr_priv_lo ?
      pair_write(master_privilege_low, i_bus.wdata, `MPSP_MASK_PRIV_LO) :
      master_privilege_low;

   assign next_master_privilege_high = wr_priv_hi ?
      pair_write(master_privilege_high, i_bus.wdata, `MPSP_MASK_PRIV_HI) :
      master_privilege_high;

   // A write that hits no register leaves all three unchanged.
   // Policy registers. Reset is the only way to clear a set lock, which
   // is what makes the locks trustworthy against later software.
   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         master_security_policy <= `MPSP_RST_VAL;
         master_privilege_low   <= `MPSP_RST_VAL;
         master_privilege_high  <= `MPSP_RST_VAL;
      end
      else
      begin
         master_security_policy <= next_master_security_policy;
         master_privilege_low   <= next_master_privilege_low;
         master_privilege_high  <= next_master_privilege_high;
      end
   end

   // Read selection. The stored registers never hold reserved ones,
   // so the raw values already read zero there.
   // At most one address compare is true, so the order is free.
   // unmapped and reserved read zero
   assign rd_sel = hit_sec     ? master_security_policy :
                   hit_priv_lo ? master_privilege_low   :
                   hit_priv_hi ? master_privilege_high  :
                   `MPSP_RD_ZERO;

   // Returning zero between reads keeps stale policy values off the
   // shared read bus, at the cost of one more multiplexer.
   // There is no error response: software can only tell a locked or
   // unmapped write from a landed one by reading the register back.
   // Read data stands only in the cycle after the strobe.
   assign next_rdata = i_bus.rd ? rd_sel : `MPSP_RD_ZERO;

   // Registered read data, one cycle after the read strobe.
   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         o_rdata <= `MPSP_RD_ZERO;
      end
      else
      begin
         o_rdata <= next_rdata;
      end
   end

   // Indicator vectors of each register.
   assign sec_ind     = indicators(master_security_policy);
   assign priv_lo_ind = indicators(master_privilege_low);
   assign priv_hi_ind = indicators(master_privilege_high);

   // Security indicator of every master group, picked by pair index.
   // The lowest pair of the security register is reserved and unused.
   assign nonsecure_sel_dma_b      = sec_ind[`MPSP_PAIR_DMA_B];
   assign nonsecure_sel_debug_port = sec_ind[`MPSP_PAIR_DEBUG_PORT];
   assign nonsecure_sel_aux_master = sec_ind[`MPSP_PAIR_AUX_MASTER];
   assign nonsecure_sel_sdhost_c   = sec_ind[`MPSP_PAIR_SDHOST_C];
   assign nonsecure_sel_sdhost_b   = sec_ind[`MPSP_PAIR_SDHOST_B];
   assign nonsecure_sel_sdhost_a   = sec_ind[`MPSP_PAIR_SDHOST_A];
   assign nonsecure_sel_ethernet   = sec_ind[`MPSP_PAIR_ETHERNET];
   assign nonsecure_sel_nand_dma   = sec_ind[`MPSP_PAIR_NAND_DMA];
   assign nonsecure_sel_graphics   = sec_ind[`MPSP_PAIR_GRAPHICS];
   assign nonsecure_sel_video_dec  = sec_ind[`MPSP_PAIR_VIDEO_DEC];
   assign nonsecure_sel_pcie       = sec_ind[`MPSP_PAIR_PCIE];
   assign nonsecure_sel_usb        = sec_ind[`MPSP_PAIR_USB];
   assign nonsecure_sel_display    = sec_ind[`MPSP_PAIR_DISPLAY];
   assign nonsecure_sel_dma_a      = sec_ind[`MPSP_PAIR_DMA_A];
   assign nonsecure_sel_aux_core   = sec_ind[`MPSP_PAIR_AUX_CORE];

   // Stored privilege indicator of every master group. Fifteen groups
   // live in the first privilege register; the crypto accelerator uses
   // the single pair of the second one.
   assign privilege_dma_b         = priv_lo_ind[`MPSP_PAIR_DMA_B];
   assign privilege_debug_port    = priv_lo_ind[`MPSP_PAIR_DEBUG_PORT];
   assign privilege_aux_master    = priv_lo_ind[`MPSP_PAIR_AUX_MASTER];
   assign privilege_sdhost_c      = priv_lo_ind[`MPSP_PAIR_SDHOST_C];
   assign privilege_sdhost_b      = priv_lo_ind[`MPSP_PAIR_SDHOST_B];
   assign privilege_sdhost_a      = priv_lo_ind[`MPSP_PAIR_SDHOST_A];
   assign privilege_ethernet      = priv_lo_ind[`MPSP_PAIR_ETHERNET];
   assign privilege_nand_dma      = priv_lo_ind[`MPSP_PAIR_NAND_DMA];
   assign privilege_graphics      = priv_lo_ind[`MPSP_PAIR_GRAPHICS];
   assign privilege_video_dec     = priv_lo_ind[`MPSP_PAIR_VIDEO_DEC];
   assign privilege_pcie          = priv_lo_ind[`MPSP_PAIR_PCIE];
   assign privilege_usb           = priv_lo_ind[`MPSP_PAIR_USB];
   assign privilege_display       = priv_lo_ind[`MPSP_PAIR_DISPLAY];
   assign privilege_dma_a         = priv_lo_ind[`MPSP_PAIR_DMA_A];
   assign privilege_aux_core      = priv_lo_ind[`MPSP_PAIR_AUX_CORE];
   assign privilege_crypto_master = priv_hi_ind[`MPSP_PAIR_CRYPTO];

   // Group 0 is the crypto accelerator; group g above it uses the
   // pair at bits 2g+1/2g of the first privilege register.
   assign privilege_stored =
   {
      privilege_dma_b,
      privilege_debug_port,
      privilege_aux_master,
      privilege_sdhost_c,
      privilege_sdhost_b,
      privilege_sdhost_a,
      privilege_ethernet,
      privilege_nand_dma,
      privilege_graphics,
      privilege_video_dec,
      privilege_pcie,
      privilege_usb,
      privilege_display,
      privilege_dma_a,
      privilege_aux_core,
      privilege_crypto_master
   };

   // Security attribute: group g uses the pair at bits 2g+3/2g+2.
   // A group with its indicator clear is secure, which is also the
   // reset state: a master stays secure until software opens it up.
   // drive type-1 security
   assign next_attr.nonsecure =
   {
      nonsecure_sel_dma_b,
      nonsecure_sel_debug_port,
      nonsecure_sel_aux_master,
      nonsecure_sel_sdhost_c,
      nonsecure_sel_sdhost_b,
      nonsecure_sel_sdhost_a,
      nonsecure_sel_ethernet,
      nonsecure_sel_nand_dma,
      nonsecure_sel_graphics,
      nonsecure_sel_video_dec,
      nonsecure_sel_pcie,
      nonsecure_sel_usb,
      nonsecure_sel_display,
      nonsecure_sel_dma_a,
      nonsecure_sel_aux_core
   };

   // The override selects come from a register outside this block on
   // this same clock, so no synchroniser stands in their path.
   // Overrides act per group, so groups may mix both sources freely.
   // Privilege attribute per group, 1 meaning supervisor.
   // 1 means supervisor
   assign next_attr.privilege = (i_priv_override_sel & privilege_stored) |
                                (~i_priv_override_sel & i_priv_in);

   // Attribute outputs come from flip-flops. The price is one cycle
   // between a change of the master's own privilege and the output;
   // the gain is a glitch-free attribute toward the fabric.
   // Reset drives every master secure and in user mode, the safest
   // state while software has not yet programmed the bank.
   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         o_attr <= '0;
      end
      else
      begin
         o_attr <= next_attr;
      end
   end

endmodule : mpsp_policy

// File: mpsp_policy_props.sv
`timescale 1ns/10ps
// Port-level checker for the policy register bank; it sees only the top ports.
module mpsp_policy_chk
(
   input wire logic                    i_clk,
   input wire logic                    i_arst_n,
   input wire mpsp_pkg::mpsp_bus_req_t i_bus,
   input wire logic [31:0]             o_rdata,
   input wire logic [15:0]             i_priv_override_sel,
   input wire logic [15:0]             i_priv_in,
   input wire mpsp_pkg::mpsp_attr_t    o_attr
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_arst_n);
   // Indicator bits 30 down to 2 of a register word, lowest first.
   function automatic logic [14:0] ev(input logic [31:0] x);
      for (int i = 0; i < 15; i++) ev[i] = x[2*i+2];
   endfunction : ev
   // Decoded reads and security write; an unmapped read must answer zero.
   wire rd_sa = i_bus.rd && i_bus.addr == 12'h218;
   wire rd_lo = i_bus.rd && i_bus.addr == 12'h200;
   wire rd_hi = i_bus.rd && i_bus.addr == 12'h204;
   wire rd_un = i_bus.rd && !(i_bus.addr inside {12'h200, 12'h204, 12'h218});
   wire wr_sa = i_bus.wr && i_bus.addr == 12'h218;
   property p_rd_idle; !i_bus.rd |=> o_rdata == 32'h0; endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data not zero");
   property p_unmapped; rd_un |=> o_rdata == 32'h0; endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   property p_sa_res; rd_sa |=> o_rdata[1:0] == 2'h0; endproperty
   a_sa_res: assert property (p_sa_res) else $error("reserved bits set");
   property p_hi_res; rd_hi |=> o_rdata[31:2] == 30'h0; endproperty
   a_hi_res: assert property (p_hi_res) else $error("reserved bits set");
   // The output leaves reset one edge after release, so a reset edge starts no attempt.
   property p_pass; i_arst_n |=> ((o_attr.privilege ^ $past(i_priv_in)) & ~$past(i_priv_override_sel)) == 16'h0;
   endproperty
   a_pass: assert property (p_pass) else $error("privilege not passed");
   property p_ns_hold; !wr_sa |=> ##1 $stable(o_attr.nonsecure); endproperty
   a_ns_hold: assert property (p_ns_hold) else $error("security changed");
   property p_sa_map; rd_sa |=> o_attr.nonsecure == ev(o_rdata); endproperty
   a_sa_map: assert property (p_sa_map) else $error("security map wrong");
   property p_lo_map; rd_lo |=> ((o_attr.privilege[15:1] ^ ev(o_rdata)) & $past(i_priv_override_sel[15:1])) == 15'h0;
   endproperty
   a_lo_map: assert property (p_lo_map) else $error("privilege map wrong");
   property p_hi_map; rd_hi && i_priv_override_sel[0] |=> o_attr.privilege[0] == o_rdata[0]; endproperty
   a_hi_map: assert property (p_hi_map) else $error("crypto privilege wrong");
   c_wr_sa: cover property (wr_sa);
   c_rd_lo: cover property (rd_lo);
   c_mix: cover property (i_priv_override_sel != 16'h0 && i_priv_override_sel != 16'hffff);
endmodule : mpsp_policy_chk

// File: mpsp_masters.sv
`timescale 1ns/10ps
// Bus masters driving their own privilege; each may change it on any cycle.
module mpsp_masters
(
   input  wire logic  i_clk,
   input  wire logic  i_arst_n,
   output logic [15:0] o_priv_in
);
   // A free-running sequence, so every pass-through bit toggles often.
   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
         o_priv_in <= 16'h5a3c;
      else
         o_priv_in <= {o_priv_in[14:0], o_priv_in[15] ^ o_priv_in[13] ^ o_priv_in[12] ^ o_priv_in[10]};
   end
endmodule : mpsp_masters

// File: mpsp_policy_tb.sv
`timescale 1ns/10ps
// Self-checking bench for the policy register bank.
module mpsp_policy_tb;
   logic                    i_clk = 1'b0;
   logic                    i_arst_n = 1'b0;
   mpsp_pkg::mpsp_bus_req_t bus = '0;
   logic [31:0]             o_rdata;
   logic [15:0]             sel = 16'h0;
   logic [15:0]             pin;
   mpsp_pkg::mpsp_attr_t    o_attr;
   logic [31:0]             st = 32'h198b5e1a;
   logic [31:0]             sh[3];
   logic [31:0]             q;
   int                      miscompares = 0;
   int                      samples_checked = 0;
   int                      k;
   // Offsets and implemented bits: security, first and second privilege.
   logic [11:0]             ad[3] = '{12'h218, 12'h200, 12'h204};
   logic [31:0]             mk[3] = '{32'hffff_fffc, 32'hffff_fffc, 32'h0000_0003};
   initial forever #25 i_clk = ~i_clk;
   mpsp_masters u_m (.i_clk(i_clk), .i_arst_n(i_arst_n), .o_priv_in(pin));
   mpsp_policy uut (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_bus(bus), .o_rdata(o_rdata),
      .i_priv_override_sel(sel), .i_priv_in(pin), .o_attr(o_attr));
   function automatic logic [31:0] rnd();
      st = st ^ (st << 13);
      st = st ^ (st >> 17);
      st = st ^ (st << 5);
      return st;
   endfunction : rnd
   function automatic logic [14:0] ev(input logic [31:0] x);
      for (int i = 0; i < 15; i++) ev[i] = x[2*i+2];
   endfunction : ev
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      samples_checked++;
      if (s !== e)
      begin
         miscompares++;
         $display("mismatch at %0t: seen %h expected %h", $time, s, e);
      end
   endtask : chk
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      bus.addr <= a;
      bus.wdata <= d;
      bus.wr <= 1'b1;
      @(posedge i_clk);
      bus.wr <= 1'b0;
      // One idle edge, so a following write never re-raises the strobe at once.
      @(posedge i_clk);
   endtask : wr
   // Read data stands only in the cycle after the strobe; taken at the edge closing it.
   task automatic rd(input logic [11:0] a, output logic [31:0] d);
      bus.addr <= a;
      bus.rd <= 1'b1;
      @(posedge i_clk);
      bus.rd <= 1'b0;
      @(posedge i_clk);
      d = o_rdata;
   endtask : rd
   // The outgoing privilege one cycle after sampling select and master inputs.
   task automatic pchk();
      logic [15:0] e;
      @(negedge i_clk);
      e = (sel & {ev(sh[1]), sh[2][0]}) | (~sel & pin);
      @(negedge i_clk);
      chk({16'h0, o_attr.privilege}, {16'h0, e});
      chk({17'h0, o_attr.nonsecure}, {17'h0, ev(sh[0])});
      @(posedge i_clk);
   endtask : pchk
   task automatic results();
      $display("checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : results
   initial
   begin
      repeat (4) @(posedge i_clk);
      i_arst_n <= 1'b1;
      @(posedge i_clk);
      for (k = 0; k < 3; k++)
      begin
         rd(ad[k], q);
         chk(q, 32'h0);
         sh[k] = 32'h0;
      end
      $display("reset values done");
      repeat (30)
      begin
         k = rnd() % 3;
         q = rnd();
         sel <= q[15:0];
         q = rnd() & 32'h5555_5555;
         sh[k] = q & mk[k];
         wr(ad[k], q);
         rd(ad[k], q);
         chk(q, sh[k]);
         pchk();
      end
      $display("unlocked writes done");
      wr(12'h208, 32'hffff_ffff);
      rd(12'h208, q);
      chk(q, 32'h0);
      rd(ad[0], q);
      chk(q, sh[0]);
      $display("unmapped access done");
      for (k = 0; k < 3; k++)
      begin
         wr(ad[k], 32'hffff_ffff);
         wr(ad[k], 32'h0);
         rd(ad[k], q);
         chk(q, mk[k]);
         sh[k] = mk[k];
      end
      sel <= 16'hffff;
      pchk();
      $display("locks done");
      i_arst_n <= 1'b0;
      @(posedge i_clk);
      i_arst_n <= 1'b1;
      @(posedge i_clk);
      rd(ad[0], q);
      chk(q, 32'h0);
      $display("second reset done");
      results();
   end
endmodule : mpsp_policy_tb
bind mpsp_policy mpsp_policy_chk u_chk (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_bus(i_bus), .o_rdata(o_rdata),
   .i_priv_override_sel(i_priv_override_sel), .i_priv_in(i_priv_in), .o_attr(o_attr));
